// ==== tb/backlight_dimming_control_tb.sv ====
// Testbench for the backlight dimming control block.
`timescale 1ns/100ps
module backlight_dimming_control_tb;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg [7:0] lane_fault = 8'h21;
  wire [7:0] rdata;
  wire [1:0] sts;
  wire [7:0] lanes;
  wire pwm_in, led, flag, sde, fsel;
  integer mismatches = 0;
  integer comparisons = 0;
  integer cycles = 0;
  // Clock, and a cycle ceiling that cuts a hang short.
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 95000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  bdc_ext_pwm u_bdc_ext_pwm (.core_clk(core_clk), .high_cycles(8'h80), .pwm_out(pwm_in));
  bdc_top u_bdc_top (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .external_dimming_input(pwm_in), .lane_fault(lane_fault), .led_pwm(led), .lane_drive(lanes),
    .backlight_on_flag(flag), .short_threshold_select(sts), .short_detect_enable(sde),
    .switching_freq_select(fsel));
  task chk(input [47:0] what, input [10:0] exp, input [10:0] got, input [3:0] tol);
    comparisons = comparisons + 1;
    if (^got === 1'bx || got + tol < exp || got > exp + tol) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge core_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(negedge core_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk("rdata", e, rdata, 0);
  endtask
  // Counts high cycles of the drive over four periods.
  task pwm(input [10:0] e);
    integer i;
    reg [10:0] n;
    n = 0;
    for (i = 0; i < 1024; i = i + 1) begin
      @(negedge core_clk);
      n = n + led;
    end
    chk("pwm", e, n, 12);
  endtask
  task t_regs;
    rd(8'h00, 8'hFF);
    rd(8'h09, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h08, 8'h07);
    chk("cfg", 11'h00F, {sde, fsel, sts}, 0);
    wr(8'h01, 8'hF8);
    rd(8'h01, 8'h00);
    wr(8'h08, 8'hFA);
    rd(8'h08, 8'h02);
    chk("cfg", 11'h00A, {sde, fsel, sts}, 0);
    wr(8'h08, 8'h05);
    rd(8'h08, 8'h05);
    chk("cfg", 11'h005, {sde, fsel, sts}, 0);
    $display("t_regs done");
  endtask
  task t_on;
    integer i;
    // Lets the input meter close two full periods, so the level frozen on entry to host mode
    // is the settled combined level.
    repeat (600) @(negedge core_clk);
    wr(8'h01, 8'h05);
    for (i = 0; i < 80100 && flag !== 1'b1; i = i + 1) @(negedge core_clk);
    chk("flag", 1, flag, 0);
    chk("lanes", 11'h0FF, lanes, 0);
    rd(8'h09, 8'hDE);
    pwm(11'd508);
    $display("t_on done");
  endtask
  task t_duty;
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h40);
    pwm(11'd256);
    wr(8'h00, 8'h00);
    pwm(11'd0);
    wr(8'h00, 8'hFF);
    pwm(11'd1020);
    wr(8'h00, 8'hC0);
    $display("t_duty done");
  endtask
  task t_modes;
    wr(8'h01, 8'h01);
    pwm(11'd384);
    rd(8'h00, 8'hC0);
    wr(8'h01, 8'h05);
    pwm(11'd384);
    wr(8'h01, 8'h03);
    wr(8'h00, 8'h10);
    pwm(11'd512);
    rd(8'h00, 8'h80);
    $display("t_modes done");
  endtask
  task t_off;
    wr(8'h01, 8'h02);
    rd(8'h09, 8'h00);
    chk("flag", 0, flag, 0);
    chk("lanes", 0, lanes, 0);
    pwm(11'd0);
    $display("t_off done");
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    t_regs;
    t_on;
    t_duty;
    t_modes;
    t_off;
    complete_run;
  end
endmodule // backlight_dimming_control_tb

// ==== tb/bdc_asserts.sv ====
// Port assertions for the backlight dimming control.
`timescale 1ns/100ps
`include "bdc_defs.vh"
module bdc_asserts (
  input wire core_clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire led_pwm,
  input wire [7:0] lane_drive,
  input wire backlight_on_flag,
  input wire [1:0] short_threshold_select,
  input wire short_detect_enable,
  input wire switching_freq_select
);
  localparam int ON_MAX = `BDC_ON_DELAY_CYC + 2;
  reg [16:0] on_age;
  wire ctl_wr = reg_wr && reg_addr == 8'h01;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Counts cycles since a switch-on write, so a late switch-on shows up.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      on_age <= 17'h00000;
    else if (ctl_wr)
      on_age <= {16'h0000, reg_wdata[0]};
    else if (on_age != 17'h00000)
      on_age <= on_age + 17'h00001;
  end
  property p_on; $rose(backlight_on_flag) |-> on_age != 0 && on_age <= ON_MAX; endproperty
  a_on: assert property (p_on) else $error("late on");
  property p_off; ctl_wr && !reg_wdata[0] |-> ##3 !backlight_on_flag && !lane_drive; endproperty
  a_off: assert property (p_off) else $error("not off");
  property p_dark; !backlight_on_flag [*3] |-> !led_pwm; endproperty
  a_dark: assert property (p_dark) else $error("pwm while off");
  property p_rsv; reg_rd && reg_addr == 8'h01 |=> reg_rdata[7:3] == 5'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_unm; reg_rd && reg_addr == 8'h05 |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_cfg;
    reg_wr && reg_addr == 8'h08 |->
      ##2 {switching_freq_select, short_threshold_select} == $past(reg_wdata[2:0], 2);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg outputs");
  property p_sde; short_detect_enable == short_threshold_select[1]; endproperty
  a_sde: assert property (p_sde) else $error("short enable");
endmodule // bdc_asserts
bind bdc_top bdc_asserts u_bdc_asserts (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .led_pwm(led_pwm), .lane_drive(lane_drive),
  .backlight_on_flag(backlight_on_flag), .short_threshold_select(short_threshold_select),
  .short_detect_enable(short_detect_enable), .switching_freq_select(switching_freq_select));

// ==== tb/bdc_ext_pwm.sv ====
// External dimming source with a 256-cycle period.
`timescale 1ns/100ps
module bdc_ext_pwm (
  input wire core_clk,
  input wire [7:0] high_cycles,
  output reg pwm_out = 1'b0
);
  reg [7:0] phase = 8'h00;
  // High while the phase is below the set high time; moves on the falling edge.
  always @(negedge core_clk) begin
    phase <= phase + 8'h01;
    pwm_out <= phase < high_cycles;
  end
endmodule // bdc_ext_pwm

// ==== verilog/bdc_defs.vh ====
// Constants for the backlight dimming control block.
// Behaviour
// - Level 0 gives near-zero current; levels 1..254 give linear duty in 1/256 steps.
// - A write to the duty level register changes brightness in host and combined modes, not in external mode.
// - Level 0xFF is full brightness; level 0x00 is minimum output.
// - Mode comes from bit 2 interpretation and bit 1 source; source=1 means external.
// - Combined mode output duty equals programmed level times measured external duty.
// - Reserved control bits read zero and writes to them do nothing.
// - Defined control bits read back their latched value.
// - Device control bits 7 and 6 always read zero.
// - Backlight-on write turns backlight on within 4 ms.
// - Backlight-off write turns backlight off at once; flag and channels read zero.
// - Duty register reads last write in host/combined modes, live brightness in external.
// - Entering host mode keeps brightness; entering other modes follows the new mode.
// - Short threshold upper bit 0 disables detection; 10 is 3.1 V, 11 is 8 V.
// - Frequency bit selects 600 kHz when 0 and 1.2 MHz when 1.
// - Channel bits enable lanes on write; read 1 only for healthy enabled lanes.
// - Backlight-on flag reads 1 while the backlight is on.
`ifndef BDC_DEFS_VH
`define BDC_DEFS_VH
`define BDC_OFS_DUTY 8'h00
`define BDC_OFS_CTRL 8'h01
`define BDC_OFS_CFG 8'h08
`define BDC_OFS_CHAN 8'h09
`define BDC_RST_DUTY 8'hFF
`define BDC_RST_CTRL 8'h00
`define BDC_RST_CFG 8'hFF
`define BDC_RST_CHAN 8'hFF
`define BDC_CTRL_MASK 8'h07
`define BDC_CFG_MASK 8'h07
`define BDC_BIT_ON 0
`define BDC_BIT_SRC 1
`define BDC_BIT_INTERP 2
`define BDC_BIT_FREQ 2
`define BDC_MODE_HOST 2'h0
`define BDC_MODE_EXT 2'h1
`define BDC_MODE_COMB 2'h2
`define BDC_CLK_HZ 20000000
`define BDC_ON_DELAY_US 4000
`define BDC_ON_DELAY_CYC ((`BDC_CLK_HZ / 1000000) * `BDC_ON_DELAY_US)
`define BDC_ON_CNT_W 17
// Last count of the start-up delay, sized to the delay counter (80000 cycles less one).
`define BDC_ON_DELAY_LAST 17'h1387F
`endif

// ==== verilog/bdc_duty_meter.v ====
// Measures the duty of the external dimming input over one of its periods.
`timescale 1ns/100ps
module bdc_duty_meter (
  input wire core_clk,
  input wire sys_rst,
  input wire external_dimming_input,
  output reg [7:0] duty
);
  reg prev_in;
  reg [15:0] high_cnt;
  reg [15:0] total_cnt;
  wire rise;
  assign rise = external_dimming_input & ~prev_in;
  // Counts high and total cycles; each rising edge closes one period.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_in <= 1'b0;
      high_cnt <= 16'h0000;
      total_cnt <= 16'h0000;
      duty <= 8'h00;
    end else begin
      prev_in <= external_dimming_input;
      if (rise) begin
        if (total_cnt != 16'h0000) begin
          if (high_cnt >= total_cnt) begin
            duty <= 8'hFF; // Input held high over the whole period.
          end else begin
            duty <= ratio(high_cnt, total_cnt);
          end
        end
        high_cnt <= 16'h0001;
        total_cnt <= 16'h0001;
      end else begin
        if (total_cnt != 16'hFFFF) begin
          total_cnt <= total_cnt + 16'h0001;
          high_cnt <= high_cnt + {15'h0000, external_dimming_input};
        end else begin
          duty <= external_dimming_input ? 8'hFF : 8'h00; // Input stuck at a level.
        end
      end
    end
  end
  // Scales high time to a 0..255 fraction of the period.
  function [7:0] ratio;
    input [15:0] hi;
    input [15:0] tot;
    reg [23:0] q;
    begin
      q = {hi, 8'h00} / {8'h00, tot};
      ratio = (q > 24'h0000FF) ? 8'hFF : q[7:0];
    end
  endfunction
endmodule // bdc_duty_meter

// ==== verilog/bdc_pwm_core.v ====
// Free-running PWM generator with 256 duty levels at the host PWM rate.
`timescale 1ns/100ps
module bdc_pwm_core (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] level,
  output reg pwm
);
  reg [7:0] phase;
  // Level 0 never drives; 255 is always on; others give level/256 duty.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 8'h00;
      pwm <= 1'b0;
    end else begin
      phase <= phase + 8'h01;
      pwm <= (level == 8'hFF) ? 1'b1 : (phase < level);
    end
  end
endmodule // bdc_pwm_core

// ==== verilog/bdc_top.v ====
// Register file, mode decode and output drive of the backlight dimming control.
`timescale 1ns/100ps
`include "bdc_defs.vh"
module bdc_top (
  input wire core_clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire external_dimming_input,
  input wire [7:0] lane_fault,
  output reg led_pwm,
  output reg [7:0] lane_drive,
  output reg backlight_on_flag,
  output reg [1:0] short_threshold_select,
  output reg short_detect_enable,
  output reg switching_freq_select
);
  reg [7:0] duty_level;
  reg [7:0] device_control;
  reg [7:0] cfg;
  reg [7:0] lane_enable;
  reg [7:0] held_level;
  reg [16:0] on_cnt;
  reg bl_on;
  reg [1:0] mode;
  reg [7:0] eff_level;
  reg [15:0] product;
  reg [7:0] rd_val;
  wire [7:0] ext_duty;
  wire pwm_raw;
  wire ctrl_wr;
  wire [7:0] ctrl_new;
  assign ctrl_wr = reg_wr && (reg_addr == `BDC_OFS_CTRL);
  assign ctrl_new = reg_wdata & `BDC_CTRL_MASK;

  bdc_duty_meter u_meter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .external_dimming_input(external_dimming_input),
    .duty(ext_duty)
  );

  // Decodes mode: source wins, then interpretation picks host or combined.
  always @* begin
    if (device_control[`BDC_BIT_SRC]) begin
      mode = `BDC_MODE_EXT;
    end else if (device_control[`BDC_BIT_INTERP]) begin
      mode = `BDC_MODE_HOST;
    end else begin
      mode = `BDC_MODE_COMB;
    end
  end

  // Picks the level in effect for the current mode.
  always @* begin
    product = {8'h00, duty_level} * {8'h00, ext_duty};
    case (mode)
      `BDC_MODE_EXT: eff_level = ext_duty;
      `BDC_MODE_COMB: eff_level = (ext_duty == 8'hFF) ? duty_level : product[15:8];
      `BDC_MODE_HOST: eff_level = held_level;
      default: eff_level = held_level;
    endcase
  end

  bdc_pwm_core u_pwm (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level(eff_level),
    .pwm(pwm_raw)
  );

  // Register writes; reserved bits are dropped on entry.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty_level <= `BDC_RST_DUTY;
      device_control <= `BDC_RST_CTRL;
      cfg <= `BDC_RST_CFG & `BDC_CFG_MASK;
      lane_enable <= `BDC_RST_CHAN;
    end else if (reg_wr) begin
      case (reg_addr)
        `BDC_OFS_DUTY: duty_level <= reg_wdata;
        `BDC_OFS_CTRL: device_control <= ctrl_new;
        `BDC_OFS_CFG: cfg <= reg_wdata & `BDC_CFG_MASK;
        `BDC_OFS_CHAN: lane_enable <= reg_wdata;
        default: duty_level <= duty_level;
      endcase
    end
  end

  // Host-mode level: updated by duty writes only in host mode; kept on entry to host mode.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      held_level <= `BDC_RST_DUTY;
    end else if (ctrl_wr && !ctrl_new[`BDC_BIT_SRC] && ctrl_new[`BDC_BIT_INTERP]
                 && (mode != `BDC_MODE_HOST)) begin
      held_level <= eff_level;
    end else if (reg_wr && (reg_addr == `BDC_OFS_DUTY) && (mode == `BDC_MODE_HOST)) begin
      held_level <= reg_wdata;
    end
  end

  // Backlight on/off sequencing: off at once, on after the start-up delay.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bl_on <= 1'b0;
      on_cnt <= 17'h00000;
    end else if (!device_control[`BDC_BIT_ON]) begin
      bl_on <= 1'b0;
      on_cnt <= 17'h00000;
    end else if (!bl_on) begin
      if (on_cnt >= `BDC_ON_DELAY_LAST) begin
        bl_on <= 1'b1;
      end else begin
        on_cnt <= on_cnt + 17'h00001;
      end
    end
  end

  // Readback mux; unmapped offsets read zero.
  always @* begin
    case (reg_addr)
      `BDC_OFS_DUTY: rd_val = (mode == `BDC_MODE_EXT) ? eff_level : duty_level;
      `BDC_OFS_CTRL: rd_val = device_control;
      `BDC_OFS_CFG: rd_val = cfg;
      `BDC_OFS_CHAN: rd_val = bl_on ? (lane_enable & ~lane_fault) : 8'h00;
      default: rd_val = 8'h00;
    endcase
  end

  // Registered outputs.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      led_pwm <= 1'b0;
      lane_drive <= 8'h00;
      backlight_on_flag <= 1'b0;
      short_threshold_select <= 2'h3;
      short_detect_enable <= 1'b1;
      switching_freq_select <= 1'b1;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rd_val;
      end
      led_pwm <= bl_on & pwm_raw;
      lane_drive <= bl_on ? lane_enable : 8'h00;
      backlight_on_flag <= bl_on;
      short_threshold_select <= cfg[1:0];
      short_detect_enable <= cfg[1];
      switching_freq_select <= cfg[`BDC_BIT_FREQ];
    end
  end
endmodule // bdc_top
